// >>> rtl/sat_map.svh
// Constants for the serial converter control block.
// Assumes inclusion by the block package users only.
`ifndef SAT_MAP_SVH
`define SAT_MAP_SVH
`define SAT_RES_BITS 12
`define SAT_CTRL_BITS 8
`define SAT_TRACK_BIT 5
// Control byte field positions, start bit at 7
`define SAT_SEL2_POS 6
`define SAT_SEL1_POS 5
`define SAT_SEL0_POS 4
`define SAT_UNI_POS 3
`define SAT_SGL_POS 2
`define SAT_MODE_HI_POS 1
`define SAT_MODE_LO_POS 0
// Internal conversion clock divider and step count
`define SAT_INT_DIV 8'h0F
`define SAT_INT_STEPS 5'h10
`define SAT_ACQ_MIN_NS 1500
`define SAT_CLK_NS 8
`define SAT_ACQ_CYC ((`SAT_ACQ_MIN_NS + `SAT_CLK_NS - 1) / `SAT_CLK_NS)
`endif

// >>> rtl/sat_pkg.sv
// Types for the serial converter control block.
// Assumes sat_map.svh supplies the numeric constants.
package sat_pkg;
  typedef enum logic [2:0] {
    SAT_IDLE = 3'b000,
    SAT_SHIFT = 3'b001,
    SAT_CONV = 3'b011,
    SAT_OUT = 3'b010,
    SAT_DONE = 3'b110
  } sat_state_t;
  typedef struct packed {
    logic [7:0] pos_sel;
    logic [7:0] neg_sel;
    logic neg_gnd;
    logic track;
  } sat_mux_t;
endpackage : sat_pkg

// >>> rtl/sat_adc_if.sv
// Serial port, strobe and channel routing logic of an 8-channel 12-bit converter.
// Assumes serial pins are asynchronous and are synchronised here; the analog
// comparator answers one decision per approximation step on comp_hi.
// Functional notes
// RL1: Data output changes on falling clock edges
// RL2: Data output released while select high
// RL3: Data input sampled on rising clock edges
// RL4: Input ignored while select is high
// RL5: Internal mode: strobe low during conversion
// RL6: External mode: one-period strobe before first decision
// RL7: External mode: strobe released while select high
// RL8: Host keeps clock duty 40 to 60 percent
// RL9: Three-cycle acquisition, hold after last bit
// RL10: Tracking starts after fifth control bit
// RL11: Single-ended: one channel versus ground
// RL12: Differential: adjacent pair, either polarity
// RL13: Twelve-bit successive approximation result
// RL14: Reconnect positive input after conversion
// RL15: Host allows at least 1.5 us acquisition
// RL16: Leading zeros skipped, first one starts
// RL17: Two mode bits pick conversion clock
// RL18: Decisions output on next twelve falls
// RL19: Unipolar binary, bipolar twos complement, MSB first; code outputs sar_q unchanged as straight binary in both modes
`timescale 1ns/1ps
`include "sat_map.svh"
module sat_adc_if (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe_n,
  output logic conversion_strobe_o,
  output logic conversion_strobe_oe_n,
  // Analog front end
  output sat_pkg::sat_mux_t mux_o,
  output logic [11:0] dac_code_o,
  input wire logic comp_hi,
  // Status
  output logic [11:0] result_o,
  output logic bipolar_o
);
  logic [1:0] sclk_s_q, cs_s_q, din_s_q;
  logic sclk_d1_q;
  logic rise, fall, cs_act;
  sat_pkg::sat_state_t st_q;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_v;
  logic [3:0] bit_cnt_q;
  logic ext_q, track_q, strobe_q;
  logic [11:0] sar_q;
  logic [3:0] step_q;
  logic [12:0] shout_q;
  logic [4:0] oc_q;
  logic [7:0] div_q;
  logic int_tick;

  function automatic logic [7:0] onehot8(input logic [2:0] i);
    onehot8 = 8'h01 << i;
  endfunction : onehot8

  // Partial control byte moved up to its final field positions
  function automatic logic [7:0] align_ctrl(input logic [7:0] c, input logic [3:0] n);
    align_ctrl = c << (4'(`SAT_CTRL_BITS) - n);
  endfunction : align_ctrl

  // Two-stage synchronisers; only the second stage feeds logic
  always_ff @(posedge clk)
  begin
    sclk_s_q <= {sclk_s_q[0], sclk};
    cs_s_q <= {cs_s_q[0], cs_n};
    din_s_q <= {din_s_q[0], din};
    sclk_d1_q <= sclk_s_q[1];
  end
  assign rise = sclk_s_q[1] & ~sclk_d1_q;
  assign fall = ~sclk_s_q[1] & sclk_d1_q;
  assign cs_act = ~cs_s_q[1];

  // Internal conversion clock enable
  always_ff @(posedge clk)
  begin
    if (!rst_n || st_q != sat_pkg::SAT_CONV || ext_q)
      div_q <= 8'h00;
    else if (int_tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end
  assign int_tick = (div_q == `SAT_INT_DIV);

  // Sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_n || !cs_act)
    begin
      st_q <= sat_pkg::SAT_IDLE; // RL4
      bit_cnt_q <= 4'h0;
      ctrl_q <= 8'h00;
    end
    else
    begin
      case (st_q)
        sat_pkg::SAT_IDLE:
        begin
          if (rise && din_s_q[1]) // RL3 RL16
          begin
            ctrl_q <= 8'h01;
            bit_cnt_q <= 4'h1;
            st_q <= sat_pkg::SAT_SHIFT;
          end
        end
        sat_pkg::SAT_SHIFT:
        begin
          if (rise && bit_cnt_q != 4'(`SAT_CTRL_BITS)) // RL3
          begin
            ctrl_q <= {ctrl_q[6:0], din_s_q[1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (fall && bit_cnt_q == 4'(`SAT_CTRL_BITS))
            st_q <= sat_pkg::SAT_CONV; // RL9
        end
        sat_pkg::SAT_CONV:
        begin
          if ((ext_q ? fall : int_tick) && step_q == 4'hB)
            st_q <= ext_q ? sat_pkg::SAT_DONE : sat_pkg::SAT_OUT;
        end
        sat_pkg::SAT_OUT:
        begin
          if (fall && oc_q == 5'h0C)
            st_q <= sat_pkg::SAT_DONE;
        end
        sat_pkg::SAT_DONE:
        begin
          if (rise && din_s_q[1]) // RL16
          begin
            ctrl_q <= 8'h01;
            bit_cnt_q <= 4'h1;
            st_q <= sat_pkg::SAT_SHIFT;
          end
        end
        default: st_q <= sat_pkg::SAT_IDLE;
      endcase
    end
  end

  // Clock mode from control byte
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ext_q <= 1'b0;
    else if (st_q == sat_pkg::SAT_SHIFT && fall && bit_cnt_q == 4'(`SAT_CTRL_BITS))
      ext_q <= ctrl_q[`SAT_MODE_HI_POS] & ctrl_q[`SAT_MODE_LO_POS]; // RL17
  end

  // Track/hold switch
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      track_q <= 1'b1;
    else if (st_q == sat_pkg::SAT_SHIFT && fall && bit_cnt_q == 4'(`SAT_TRACK_BIT))
      track_q <= 1'b1; // RL10
    else if (st_q == sat_pkg::SAT_SHIFT && fall && bit_cnt_q == 4'(`SAT_CTRL_BITS))
      track_q <= 1'b0; // RL9
    else if (st_q == sat_pkg::SAT_OUT || st_q == sat_pkg::SAT_DONE || !cs_act)
      track_q <= 1'b1; // RL14
  end

  // Successive approximation, MSB first
  always_ff @(posedge clk)
  begin
    if (!rst_n || st_q == sat_pkg::SAT_SHIFT)
    begin
      sar_q <= 12'h800;
      step_q <= 4'h0;
    end
    else if (st_q == sat_pkg::SAT_CONV && (ext_q ? fall : int_tick))
    begin
      sar_q[4'hB - step_q] <= comp_hi; // RL13
      if (step_q != 4'hB)
        sar_q[4'hA - step_q] <= 1'b1;
      step_q <= step_q + 4'h1;
    end
  end
  assign dac_code_o = sar_q;

  // Strobe: external one-period pulse, internal low while busy
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      strobe_q <= 1'b1;
    else if (!cs_act)
      strobe_q <= ~ext_q;
    else if (st_q == sat_pkg::SAT_SHIFT && fall && bit_cnt_q == 4'(`SAT_CTRL_BITS))
      strobe_q <= ~(ctrl_q[`SAT_MODE_HI_POS] & ctrl_q[`SAT_MODE_LO_POS]) ? 1'b0 : 1'b1; // RL5 RL6
    else if (ext_q && strobe_q && fall)
      strobe_q <= 1'b0; // RL6
    else if (!ext_q && st_q == sat_pkg::SAT_OUT)
      strobe_q <= 1'b1; // RL5
  end
  // External mode: the fall that ends the pulse takes the MSB decision
  assign conversion_strobe_o = strobe_q;
  assign conversion_strobe_oe_n = ext_q & ~cs_act; // RL7

  // Output shifter, updates on falls; internal mode loads it on the last conversion tick
  always_ff @(posedge clk)
  begin
    if (!rst_n || !cs_act)
    begin
      shout_q <= 13'h0000;
      oc_q <= 5'h00;
    end
    else if (st_q == sat_pkg::SAT_CONV && ext_q && fall)
      shout_q[12] <= comp_hi; // RL18 RL1
    else if (st_q == sat_pkg::SAT_CONV && !ext_q && int_tick && step_q == 4'hB)
    begin
      shout_q <= {1'b0, sar_q[11:1], comp_hi};
      oc_q <= 5'h00;
    end
    else if (st_q == sat_pkg::SAT_OUT && fall)
    begin
      shout_q <= {shout_q[11:0], 1'b0}; // RL1 RL19
      oc_q <= oc_q + 5'h01;
    end
    else if (fall)
      shout_q[12] <= 1'b0;
  end
  assign dout_o = shout_q[12];
  assign dout_oe_n = ~cs_act; // RL2

  // Status result and channel routing
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      result_o <= 12'h000;
    else if (st_q == sat_pkg::SAT_DONE || st_q == sat_pkg::SAT_OUT)
      result_o <= sar_q; // RL19
  end
  // Routing follows the bits already received, so acquisition sees its channel
  assign ctrl_v = (st_q == sat_pkg::SAT_SHIFT) ? align_ctrl(ctrl_q, bit_cnt_q) : ctrl_q;
  assign bipolar_o = ~ctrl_v[`SAT_UNI_POS];

  always_comb
  begin
    logic [2:0] s;
    logic [2:0] pair;
    s = {ctrl_v[`SAT_SEL1_POS], ctrl_v[`SAT_SEL0_POS], ctrl_v[`SAT_SEL2_POS]};
    pair = {ctrl_v[`SAT_SEL1_POS], ctrl_v[`SAT_SEL0_POS], 1'b0};
    mux_o.track = track_q;
    if (ctrl_v[`SAT_SGL_POS])
    begin
      mux_o.pos_sel = onehot8(s); // RL11
      mux_o.neg_sel = 8'h00;
      mux_o.neg_gnd = 1'b1;
    end
    else
    begin
      mux_o.pos_sel = onehot8(pair | {2'b00, ctrl_v[`SAT_SEL2_POS]}); // RL12
      mux_o.neg_sel = onehot8(pair | {2'b00, ~ctrl_v[`SAT_SEL2_POS]});
      mux_o.neg_gnd = 1'b0;
    end
  end
endmodule : sat_adc_if

// >>> verif/sat_adc_if_props.sv
// Port checker for sat_adc_if.
// Assumes sclk is far slower than clk and is bound to the top module.
`timescale 1ns/1ps
module sat_adc_if_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dout_o,
  input wire logic dout_oe_n,
  input wire logic conversion_strobe_o,
  input wire logic conversion_strobe_oe_n,
  // Analog side
  input wire sat_pkg::sat_mux_t mux_o,
  input wire logic [11:0] dac_code_o
);
  logic sclk_q;
  logic [3:0] age_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk) sclk_q <= sclk;
  // Cycles since the last serial clock fall, saturating
  always_ff @(posedge clk)
    if (!rst_n) age_q <= 4'hF;
    else if (sclk_q && !sclk) age_q <= 4'h0;
    else if (age_q != 4'hF) age_q <= age_q + 4'h1;
  sequence s_strb_hold; conversion_strobe_o [*8]; endsequence
  property p_dout_edge; $changed(dout_o) && !cs_n && !$past(cs_n, 4) |-> age_q <= 4'h6; endproperty
  a_dout_edge: assert property (p_dout_edge) else $error("dout moved off a fall");
  property p_dout_rel; cs_n [*3] |-> dout_oe_n; endproperty
  a_dout_rel: assert property (p_dout_rel) else $error("dout driven while idle");
  property p_strb_pulse; $rose(conversion_strobe_o) |-> s_strb_hold; endproperty
  a_strb_pulse: assert property (p_strb_pulse) else $error("strobe glitch");
  property p_strb_drv; !cs_n [*3] |-> !conversion_strobe_oe_n; endproperty
  a_strb_drv: assert property (p_strb_drv) else $error("strobe released");
  property p_hold_edge; $fell(mux_o.track) |-> age_q <= 4'h6; endproperty
  a_hold_edge: assert property (p_hold_edge) else $error("hold off a fall");
  property p_dac_run; $fell(mux_o.track) |-> ##[0:40] $changed(dac_code_o); endproperty
  a_dac_run: assert property (p_dac_run) else $error("no trial code");
  property p_pos_hot; $onehot(mux_o.pos_sel); endproperty
  a_pos_hot: assert property (p_pos_hot) else $error("positive select not one-hot");
  property p_pair; !mux_o.neg_gnd |-> mux_o.neg_sel == {mux_o.pos_sel[6], mux_o.pos_sel[7],
    mux_o.pos_sel[4], mux_o.pos_sel[5], mux_o.pos_sel[2], mux_o.pos_sel[3],
    mux_o.pos_sel[0], mux_o.pos_sel[1]}; endproperty
  a_pair: assert property (p_pair) else $error("pair mismatch");
endmodule : sat_adc_if_props
bind sat_adc_if sat_adc_if_props u_props (.clk, .rst_n, .sclk, .cs_n, .dout_o, .dout_oe_n,
  .conversion_strobe_o, .conversion_strobe_oe_n, .mux_o, .dac_code_o);

// >>> verif/sat_host.sv
// Host serial master model driving select, clock and data.
// Assumes clk is the 8 ns bench clock; sclk runs 20 clk a period in frames, plus one stray pulse after each deselect.
`timescale 1ns/1ps
module sat_host (
  // Bench clock
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout_o,
  input wire logic dout_oe_n,
  input wire logic strb
);
  logic last_q = 1'b0;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Released line shows the inverse, never a stale bit
  wire pin = dout_oe_n ? ~last_q : dout_o;
  always @(posedge clk) if (!dout_oe_n) last_q <= dout_o;
  task sel(input logic v);
    @(negedge clk) cs_n = v;
    if (v) din = 1'b1;
    repeat (4) @(negedge clk);
    // A stray start bit while deselected must not reach the next frame
    if (v)
    begin
      repeat (20) @(negedge clk);
      sclk = 1'b1;
      repeat (20) @(negedge clk);
      sclk = 1'b0;
      repeat (148) @(negedge clk);
    end
  endtask : sel
  task xfer(input int n, input logic [31:0] tx, output logic [31:0] rx, output logic [31:0] sx);
    rx = '0;
    sx = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      din = tx[i];
      repeat (10) @(negedge clk);
      sclk = 1'b1;
      rx[i] = pin;
      sx[i] = strb;
      repeat (10) @(negedge clk);
      sclk = 1'b0;
    end
  endtask : xfer
endmodule : sat_host

// >>> verif/sat_adc_if_bench.sv
// Self-checking bench for sat_adc_if.
// Assumes sat_host drives the pins and an ideal comparator answers.
`timescale 1ns/1ps
module sat_adc_if_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] vin = 12'h000;
  logic [31:0] rx;
  logic [31:0] sx;
  int n;
  int err_count = 0;
  int checks_done = 0;
  wire sclk, cs_n, din, dout_o, dout_oe_n, strb, strb_oe_n, bip;
  wire sat_pkg::sat_mux_t mux_o;
  wire [11:0] dac;
  wire [11:0] res;
  wire comp_hi = vin >= dac;
  always #4 clk = ~clk;
  sat_adc_if uut (.clk, .rst_n, .sclk, .cs_n, .din, .dout_o, .dout_oe_n,
    .conversion_strobe_o(strb), .conversion_strobe_oe_n(strb_oe_n), .mux_o,
    .dac_code_o(dac), .comp_hi, .result_o(res), .bipolar_o(bip));
  sat_host host (.clk, .sclk, .cs_n, .din, .dout_o, .dout_oe_n, .strb);
  task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task end_of_test;
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (50000) @(posedge clk);
    err_count++;
    $display("ERROR run expected done seen timeout");
    end_of_test();
  end
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("dout_oe_n", 1, dout_oe_n);
    for (int i = 0; i < 16; i++)
    begin
      host.sel(0);
      host.xfer(6, {26'h0, 1'b1, i[0], i[2], i[1], i[1], i[3]}, rx, sx);
      repeat (8) @(negedge clk);
      chk("pos_sel", 8'h01 << i[2:0], mux_o.pos_sel);
      chk("neg_gnd", i[3], mux_o.neg_gnd);
      if (!i[3]) chk("neg_sel", 8'h01 << (i[2:0] ^ 3'h1), mux_o.neg_sel);
      chk("track", 1, mux_o.track);
      chk("loop bipolar", !i[1], bip);
      host.sel(1);
    end
    vin = 12'hA5C;
    host.sel(0);
    host.xfer(27, {5'h0, 3'b000, 8'hFF, 16'h0}, rx, sx);
    chk("ext data", vin, rx[14:3]);
    chk("ext strobe", 2'b10, sx[15:14]);
    chk("ext result", vin, res);
    chk("bipolar", 0, bip);
    host.sel(1);
    chk("strobe oe", 1, strb_oe_n);
    chk("track end", 1, mux_o.track);
    vin = 12'hFFF;
    host.sel(0);
    host.xfer(8, 32'hFA, rx, sx);
    repeat (8) @(negedge clk);
    chk("int strobe", 0, strb);
    chk("hold", 0, mux_o.track);
    n = 0;
    while (strb !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk("conv time", 1, n > 150 && n < 400);
    host.xfer(16, 32'h0, rx, sx);
    chk("int data", vin, rx[14:3]);
    chk("int result", vin, res);
    host.sel(1);
    chk("int strobe oe", 0, strb_oe_n);
    chk("track back", 1, mux_o.track);
    end_of_test();
  end
endmodule : sat_adc_if_bench
